// >>> csc_top.sv
// Channel setup controller: setup menus, remote pins and channel state
`timescale 1ns/100ps
module csc_top import csc_pkg::*; #(
    parameter int unsigned ENTER_CYC = ENTER_CYC_DEF,
    parameter int unsigned EXIT_CYC = EXIT_CYC_DEF,
    parameter int unsigned BLANK_CYC = BLANK_CYC_DEF,
    parameter int unsigned ACK_CYC = ACK_CYC_DEF,
    parameter int unsigned FAST_CYC = FAST_CYC_DEF,
    parameter int unsigned SLOT_CYC = SLOT_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NBTN-1:0] btn_pin,
    input wire logic fader_pin,
    input wire logic [1:0] gpio_i,
    input wire csc_cfg_t nv_rd_data,
    output logic [1:0] gpio_o,
    output logic [1:0] gpio_oe,
    output logic nv_wr,
    output csc_cfg_t nv_wr_data,
    output csc_lamps_t lamps,
    output logic pgm_route,
    output logic aud_route,
    output logic pfl_route,
    output logic second_input_select_sel,
    output logic chan_on,
    output logic fader_open,
    output logic chan_live,
    output logic setup_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    if (ENTER_CYC < 2 || EXIT_CYC < 2 || BLANK_CYC < 1 || ACK_CYC < 1 || FAST_CYC < 1
        || SLOT_CYC < 1) begin : g_chk
        $error("csc_top: timing counts too small");
    end

    localparam int NS = NBTN + 3;
    csc_state_t state_r, state_nxt;
    csc_cfg_t cfg_r, cfg_nxt;
    csc_lamps_t lamps_nxt;
    logic [NS-1:0] s1_r, s2_r, prv_r;
    logic [NBTN-1:0] tog_r, mflash;
    logic [1:0] gp_asrt, gp_func, gp_prv_r, gp_tog_r, gpo_nxt;
    logic [2:0] sel_r, sel_nxt, aud_cnt_r;
    logic [31:0] hold_r, tmr_r, ack_r, fast_r, slot_tmr_r;
    logic [4:0] slot_r;
    logic pin_r, pin_nxt, load_r, hold_blk_r, fast_ph_r, commit, live_nxt;

    function automatic logic act_hit(csc_cfg_t c, logic [1:0] f, logic [2:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 2; i++) begin
            hit = hit | (f[i] & (c.pin[i].act == a));
        end
        return hit;
    endfunction

    function automatic logic force_sel(logic [2:0] m, logic t);
        return (m == MD_FORCE_ON) | ((m != MD_FORCE_OFF) & t);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers and press detection
    // ----------------------------------------------------------------
    // No debounce here: panel buttons are assumed clean or filtered upstream
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            prv_r <= '0;
        end else begin
            s1_r <= {gpio_i, fader_pin, btn_pin};
            s2_r <= s1_r;
            prv_r <= s2_r;
        end
    end

    wire [NBTN-1:0] held = s2_r[NBTN-1:0];
    wire [NBTN-1:0] press = held & ~prv_r[NBTN-1:0];
    wire both = held[BTN_PGM] & held[BTN_AUD];
    wire fader_up = s2_r[NBTN];
    wire [1:0] pin_lvl = s2_r[NS-1:NBTN+1];

    // ----------------------------------------------------------------
    // Remote pin inputs and output levels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_pin
        assign gp_asrt[i] = ~(pin_lvl[i] ^ cfg_r.pin[i].fn[FN_AH]);
        assign gp_func[i] = ~cfg_r.pin[i].fn[FN_OUT]
            & (cfg_r.pin[i].fn[FN_MOM] ? gp_asrt[i] : gp_tog_r[i]);
        assign gpo_nxt[i] = ~((live_nxt & (cfg_r.pin[i].act == ACT_CHON))
            ^ cfg_r.pin[i].fn[FN_AH]);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gp_prv_r <= '0;
            gp_tog_r <= '0;
        end else begin
            gp_prv_r <= gp_asrt;
            // Polarity is still the reset default while loading, so any edge then is false
            gp_tog_r <= gp_tog_r ^ (gp_asrt & ~gp_prv_r & {2{~load_r}});
        end
    end

    // ----------------------------------------------------------------
    // Channel behaviour in normal operation
    // ----------------------------------------------------------------
    wire in_norm = (state_r == ST_NORM);
    wire [2:0] on_mode = cfg_r.mode[BTN_ON];
    wire always_on = (on_mode >= ON_MD_ALWAYS);
    wire on_dark = (on_mode == ON_MD_DARK);
    wire led_by_pin = (on_mode == ON_MD_PIN5) | (on_mode == ON_MD_PIN6);
    wire chon_nxt = always_on | (tog_r[BTN_ON] ^ act_hit(cfg_r, gp_func, ACT_CHON));
    wire fopen_nxt = fader_up | act_hit(cfg_r, gp_func, ACT_FADER);
    assign live_nxt = chon_nxt & fopen_nxt;
    wire pgm_nxt = force_sel(cfg_r.mode[BTN_PGM], tog_r[BTN_PGM]);
    wire aud_nxt = force_sel(cfg_r.mode[BTN_AUD], tog_r[BTN_AUD]);
    wire inp_nxt = force_sel(cfg_r.mode[BTN_INP], tog_r[BTN_INP]);
    // Audition presses that belong to the entry gesture must not toggle routing
    wire [NBTN-1:0] tog_mask = {{(NBTN-2){1'b1}}, ~held[BTN_PGM], 1'b1};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tog_r <= '0;
        end else if (in_norm) begin
            tog_r <= tog_r ^ (press & tog_mask);
        end
    end

    // ----------------------------------------------------------------
    // Setup sequencing
    // ----------------------------------------------------------------
    wire [2:0] act_max = cfg_r.pin[pin_r].fn[FN_OUT] ? ACT_OUT_MAX : ACT_IN_MAX;
    wire hold_done_in = (hold_r == ENTER_CYC - 1);
    wire hold_done_out = (hold_r == EXIT_CYC - 1);
    wire gp_entry = in_norm & held[BTN_PGM] & press[BTN_AUD]
        & (aud_cnt_r == 3'(AUD_PRESSES - 1));
    wire hold_run = both & ~hold_blk_r & (in_norm | (state_r == ST_MODE));

    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        pin_nxt = pin_r;
        cfg_nxt = cfg_r;
        commit = 1'b0;
        case (state_r)
            ST_NORM: begin
                if (gp_entry) begin
                    state_nxt = ST_BLANK;
                    pin_nxt = 1'b0;
                end else if (hold_done_in) begin
                    state_nxt = ST_MODE;
                end
            end
            ST_BLANK: begin
                if (tmr_r == BLANK_CYC - 1) begin
                    state_nxt = ST_FUNC;
                    sel_nxt = cfg_r.pin[pin_r].fn;
                end
            end
            ST_FUNC: begin
                if (press[BTN_ON]) begin
                    cfg_nxt.pin[pin_r].fn = sel_r;
                    commit = 1'b1;
                    state_nxt = ST_ACT;
                    sel_nxt = (sel_r[FN_OUT] && cfg_r.pin[pin_r].act > ACT_OUT_MAX) ?
                        ACT_NONE : cfg_r.pin[pin_r].act;
                end else if (press[BTN_PGM]) begin
                    sel_nxt = sel_r + 3'h1;
                end
            end
            ST_ACT: begin
                if (press[BTN_ON]) begin
                    cfg_nxt.pin[pin_r].act = sel_r;
                    commit = 1'b1;
                    if (pin_r) begin
                        state_nxt = ST_NORM;
                    end else begin
                        pin_nxt = 1'b1;
                        state_nxt = ST_FUNC;
                        sel_nxt = cfg_r.pin[1].fn;
                    end
                end else if (press[BTN_PGM]) begin
                    sel_nxt = (sel_r >= act_max) ? ACT_NONE : sel_r + 3'h1;
                end
            end
            ST_MODE: begin
                if (hold_done_out) begin
                    state_nxt = ST_NORM;
                    commit = 1'b1;
                end else begin
                    for (int b = 0; b < NBTN; b++) begin
                        if (press[b] & ~both) begin
                            cfg_nxt.mode[b] = (cfg_r.mode[b] >= MODE_MAX[b]) ?
                                3'h0 : cfg_r.mode[b] + 3'h1;
                        end
                    end
                end
            end
            default: state_nxt = ST_NORM;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_NORM;
            sel_r <= '0;
            pin_r <= 1'b0;
            cfg_r <= CFG_RST;
            load_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            pin_r <= pin_nxt;
            load_r <= 1'b0;
            cfg_r <= load_r ? nv_rd_data : cfg_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // A hold must restart after each state change, so held buttons do not chain
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hold_r <= '0;
            hold_blk_r <= 1'b0;
            aud_cnt_r <= '0;
            tmr_r <= '0;
            ack_r <= '0;
            fast_r <= '0;
            fast_ph_r <= 1'b0;
            slot_tmr_r <= '0;
            slot_r <= '0;
        end else begin
            hold_r <= (hold_run && state_nxt == state_r) ? hold_r + 32'h1 : 32'h0;
            hold_blk_r <= (state_nxt != state_r) | (hold_blk_r & both);
            aud_cnt_r <= (in_norm & held[BTN_PGM] & ~gp_entry) ?
                aud_cnt_r + {2'h0, press[BTN_AUD]} : 3'h0;
            tmr_r <= (state_r == ST_BLANK && state_nxt == ST_BLANK) ? tmr_r + 32'h1 : 32'h0;
            ack_r <= (commit && state_r != ST_MODE) ? ACK_CYC :
                (ack_r != 32'h0) ? ack_r - 32'h1 : 32'h0;
            fast_r <= (fast_r == FAST_CYC - 1) ? 32'h0 : fast_r + 32'h1;
            fast_ph_r <= fast_ph_r ^ (fast_r == FAST_CYC - 1);
            if (state_r != ST_MODE) begin
                slot_tmr_r <= 32'h0;
                slot_r <= 5'h0;
            end else if (slot_tmr_r == SLOT_CYC - 1) begin
                slot_tmr_r <= 32'h0;
                slot_r <= (slot_r == 5'(SLOTS - 1)) ? 5'h0 : slot_r + 5'h1;
            end else begin
                slot_tmr_r <= slot_tmr_r + 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Lamps
    // ----------------------------------------------------------------
    for (genvar b = 0; b < NBTN; b++) begin : g_flash
        assign mflash[b] = ~slot_r[0] & (slot_r[4:1] <= {1'b0, cfg_r.mode[b]});
    end

    always_comb begin
        lamps_nxt = '0;
        case (state_r)
            ST_NORM: begin
                lamps_nxt.program_bus_select = pgm_nxt;
                lamps_nxt.audition_bus_select = aud_nxt;
                lamps_nxt.pfl = tog_r[BTN_PFL];
                lamps_nxt.inp = inp_nxt;
                lamps_nxt.on_red = led_by_pin ? act_hit(cfg_r, gp_func, ACT_RED) :
                    ~on_dark & chon_nxt & ~live_nxt;
                lamps_nxt.on_green = led_by_pin ? act_hit(cfg_r, gp_func, ACT_GREEN) :
                    ~on_dark & live_nxt;
            end
            ST_FUNC, ST_ACT: begin
                lamps_nxt.on_green = sel_r[FN_MOM];
                lamps_nxt.pfl = sel_r[FN_AH];
                lamps_nxt.audition_bus_select = sel_r[FN_OUT];
                lamps_nxt.program_bus_select = (ack_r != 32'h0) & fast_ph_r;
            end
            ST_MODE: begin
                lamps_nxt.program_bus_select = mflash[BTN_PGM];
                lamps_nxt.audition_bus_select = mflash[BTN_AUD];
                lamps_nxt.pfl = mflash[BTN_PFL];
                lamps_nxt.on_green = mflash[BTN_ON];
                lamps_nxt.inp = mflash[BTN_INP];
            end
            default: lamps_nxt = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gpio_o <= '0;
            gpio_oe <= '0;
            nv_wr <= 1'b0;
            nv_wr_data <= CFG_RST;
            lamps <= '0;
            pgm_route <= 1'b0;
            aud_route <= 1'b0;
            pfl_route <= 1'b0;
            second_input_select_sel <= 1'b0;
            chan_on <= 1'b0;
            fader_open <= 1'b0;
            chan_live <= 1'b0;
            setup_active <= 1'b0;
        end else begin
            gpio_o <= gpo_nxt;
            gpio_oe <= {cfg_r.pin[1].fn[FN_OUT], cfg_r.pin[0].fn[FN_OUT]};
            nv_wr <= commit;
            nv_wr_data <= cfg_nxt;
            lamps <= lamps_nxt;
            pgm_route <= pgm_nxt;
            aud_route <= aud_nxt;
            pfl_route <= tog_r[BTN_PFL];
            second_input_select_sel <= inp_nxt;
            chan_on <= chon_nxt;
            fader_open <= fopen_nxt;
            chan_live <= live_nxt;
            setup_active <= (state_nxt != ST_NORM);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_gp_entry: assert property (gp_entry |=> state_r == ST_BLANK)
        else $error("pin setup not entered");
    a_blank_dark: assert property (state_r == ST_BLANK ##1 state_r == ST_BLANK |-> lamps == '0)
        else $error("lamps lit during blank");
    a_func_step: assert property (state_r == ST_FUNC && press[BTN_PGM] && !press[BTN_ON]
        |=> sel_r == $past(sel_r) + 3'h1)
        else $error("function did not step");
    a_func_lamps: assert property (state_r == ST_FUNC
        |=> {lamps.audition_bus_select, lamps.pfl, lamps.on_green} == $past(sel_r))
        else $error("function lamps wrong");
    a_commit_store: assert property (state_r == ST_FUNC && press[BTN_ON] && !pin_r
        |=> nv_wr && nv_wr_data.pin[0].fn == $past(sel_r))
        else $error("function not stored");
    a_ack_flash: assert property (state_r == ST_FUNC && press[BTN_ON]
        |=> ack_r == ACK_CYC ##1 ack_r == ACK_CYC - 1)
        else $error("ack flash not started");
    a_out_wrap: assert property (state_r == ST_ACT && cfg_r.pin[pin_r].fn[FN_OUT]
        && sel_r == ACT_OUT_MAX && press[BTN_PGM] && !press[BTN_ON] |=> sel_r == ACT_NONE)
        else $error("output action did not wrap");
    a_second_pin: assert property (state_r == ST_ACT && !pin_r && press[BTN_ON]
        |=> state_r == ST_FUNC && pin_r)
        else $error("second pin not offered");
    a_leave_setup: assert property (state_r == ST_ACT && pin_r && press[BTN_ON]
        |=> state_r == ST_NORM ##1 !setup_active)
        else $error("setup not left");
    a_mode_wrap: assert property (state_r == ST_MODE && !hold_done_out && press[BTN_PGM]
        && !both && !load_r && cfg_r.mode[BTN_PGM] == MODE_MAX[BTN_PGM]
        |=> cfg_r.mode[BTN_PGM] == 3'h0)
        else $error("mode did not wrap");
    a_pgm_forced: assert property (cfg_r.mode[BTN_PGM] == MD_FORCE_OFF |=> !pgm_route)
        else $error("forced off routing active");
    a_always_on: assert property (always_on |=> chan_on)
        else $error("channel not held on");
    a_pin_drive: assert property (cfg_r.pin[0].fn[FN_OUT] && cfg_r.pin[0].act == ACT_CHON
        && live_nxt |=> gpio_oe[0] && gpio_o[0] == $past(cfg_r.pin[0].fn[FN_AH]))
        else $error("live output level wrong");

    c_pin_setup_done: cover property (state_r == ST_ACT && pin_r && press[BTN_ON]);
    c_mode_entered: cover property (state_r == ST_NORM ##1 state_r == ST_MODE);
    c_pin_chan_on: cover property (gp_func[0] && cfg_r.pin[0].act == ACT_CHON);
endmodule

// >>> csc_pkg.sv
// Constants and types shared by the channel setup controller
package csc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int T_ENTER_MS = 5000;
    localparam int T_EXIT_MS = 2000;
    localparam int T_BLANK_MS = 500;
    localparam int T_ACK_MS = 1000;
    localparam int T_FAST_MS = 50;
    localparam int T_SLOT_MS = 250;
    localparam int ENTER_CYC_DEF = T_ENTER_MS * CYC_PER_MS;
    localparam int EXIT_CYC_DEF = T_EXIT_MS * CYC_PER_MS;
    localparam int BLANK_CYC_DEF = T_BLANK_MS * CYC_PER_MS;
    localparam int ACK_CYC_DEF = T_ACK_MS * CYC_PER_MS;
    localparam int FAST_CYC_DEF = T_FAST_MS * CYC_PER_MS;
    localparam int SLOT_CYC_DEF = T_SLOT_MS * CYC_PER_MS;
    localparam int AUD_PRESSES = 5;
    // Flash sequence: eight on/off pairs plus a gap
    localparam int SLOTS = 20;
    localparam int NBTN = 5;
    localparam int BTN_PGM = 0;
    localparam int BTN_AUD = 1;
    localparam int BTN_PFL = 2;
    localparam int BTN_ON = 3;
    localparam int BTN_INP = 4;
    // Modes are held as mode number minus one
    localparam logic [2:0] MODE_MAX [NBTN] = '{3'h2, 3'h2, 3'h5, 3'h7, 3'h2};
    localparam logic [2:0] MD_FORCE_ON = 3'h1;
    localparam logic [2:0] MD_FORCE_OFF = 3'h2;
    localparam logic [2:0] ON_MD_DARK = 3'h2;
    localparam logic [2:0] ON_MD_ALWAYS = 3'h2;
    localparam logic [2:0] ON_MD_PIN5 = 3'h4;
    localparam logic [2:0] ON_MD_PIN6 = 3'h5;
    localparam int FN_MOM = 0;
    localparam int FN_AH = 1;
    localparam int FN_OUT = 2;
    localparam logic [2:0] ACT_NONE = 3'h0;
    localparam logic [2:0] ACT_CHON = 3'h1;
    localparam logic [2:0] ACT_RED = 3'h2;
    localparam logic [2:0] ACT_GREEN = 3'h3;
    localparam logic [2:0] ACT_FADER = 3'h4;
    localparam logic [2:0] ACT_IN_MAX = ACT_FADER;
    localparam logic [2:0] ACT_OUT_MAX = ACT_CHON;
    typedef struct packed {
        logic [2:0] act;
        logic [2:0] fn;
    } csc_pin_cfg_t;
    typedef struct packed {
        csc_pin_cfg_t [1:0] pin;
        logic [NBTN-1:0][2:0] mode;
    } csc_cfg_t;
    typedef struct packed {
        logic program_bus_select;
        logic audition_bus_select;
        logic pfl;
        logic on_red;
        logic on_green;
        logic inp;
    } csc_lamps_t;
    typedef enum logic [2:0] {ST_NORM, ST_BLANK, ST_FUNC, ST_ACT, ST_MODE} csc_state_t;
    localparam csc_cfg_t CFG_RST = '0;
endpackage

// >>> csc_far_model.sv
// Far side model: setting storage and remote equipment on the two pins
`timescale 1ns/100ps
module csc_far_model import csc_pkg::*; (
    input wire logic clk_sys,
    input wire logic nv_wr,
    input wire csc_cfg_t nv_wr_data,
    output csc_cfg_t nv_rd_data,
    input wire logic [1:0] gpio_o,
    input wire logic [1:0] gpio_oe,
    input wire logic [1:0] ext_drv,
    output logic [1:0] gpio_wire,
    output logic [7:0] wr_count
);
    // ----------------------------------------
    // Storage keeps its content through reset
    // ----------------------------------------
    initial nv_rd_data = CFG_RST;
    initial wr_count = 8'h00;
    always @(posedge clk_sys) begin
        if (nv_wr) begin
            nv_rd_data <= nv_wr_data;
            wr_count <= wr_count + 8'h01;
        end
    end
    // Remote equipment drives only where the pin is not an output
    assign gpio_wire = (gpio_oe & gpio_o) | (~gpio_oe & ext_drv);
endmodule

// >>> test_channel_setup_controller.sv
// Self-checking bench for the channel setup controller
`timescale 1ns/100ps
module test_channel_setup_controller import csc_pkg::*;;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [NBTN-1:0] btn = '0;
    logic fader = 1'b0;
    logic [1:0] ext = 2'h0;
    logic [1:0] gpio_w, gpio_o, gpio_oe;
    logic [7:0] wr_count;
    csc_cfg_t nv_rd, nv_wd;
    csc_lamps_t lamps;
    logic nv_wr, pgm_route, aud_route, pfl_route, second_input_select_sel;
    logic chan_on, fader_open, chan_live, setup_active;
    int num_errors = 0;
    int check_count = 0;
    int lit_n, tog_n;
    always #2 clk_sys = ~clk_sys;
    // Confirmation flash keeps its full length; only its start is looked at
    csc_top #(.ENTER_CYC(40), .EXIT_CYC(20), .BLANK_CYC(8), .FAST_CYC(3),
        .SLOT_CYC(2)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .btn_pin(btn),
        .fader_pin(fader), .gpio_i(gpio_w), .nv_rd_data(nv_rd), .gpio_o(gpio_o),
        .gpio_oe(gpio_oe), .nv_wr(nv_wr), .nv_wr_data(nv_wd), .lamps(lamps),
        .pgm_route(pgm_route), .aud_route(aud_route), .pfl_route(pfl_route),
        .second_input_select_sel(second_input_select_sel), .chan_on(chan_on), .fader_open(fader_open),
        .chan_live(chan_live), .setup_active(setup_active));
    csc_far_model far (.clk_sys(clk_sys), .nv_wr(nv_wr), .nv_wr_data(nv_wd),
        .nv_rd_data(nv_rd), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .ext_drv(ext),
        .gpio_wire(gpio_w), .wr_count(wr_count));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Press is held past the synchroniser, released long enough to be seen low
    task automatic press(input int idx, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            btn[idx] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            btn[idx] <= 1'b0;
            step(3);
        end
    endtask
    task automatic sample(input int n);
        logic prev;
        lit_n = 0;
        tog_n = 0;
        prev = lamps.program_bus_select;
        repeat (n) begin
            step(1);
            lit_n += int'(lamps.audition_bus_select);
            tog_n += int'(lamps.program_bus_select !== prev);
            prev = lamps.program_bus_select;
        end
    endtask
    task automatic hold_both(input int n);
        @(posedge clk_sys);
        btn <= 5'h03;
        repeat (n) @(posedge clk_sys);
        btn <= 5'h00;
        step(6);
    endtask
    task automatic set_ext(input logic v);
        @(posedge clk_sys);
        ext[0] <= v;
        step(6);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        step(20000);
        num_errors++;
        complete_run;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        step(4);
        check("setup_active", setup_active, 0);
        @(posedge clk_sys);
        btn[BTN_PGM] <= 1'b1;
        press(BTN_AUD, AUD_PRESSES);
        check("setup_active", setup_active, 1);
        check("lamps blank", lamps, 0);
        @(posedge clk_sys);
        btn[BTN_PGM] <= 1'b0;
        step(12);
        check("pin0 fn", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 0);
        press(BTN_PGM, 2);
        check("pin0 fn", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 3'b010);
        press(BTN_ON, 1);
        check("stored fn", nv_rd.pin[0].fn, 3'h2);
        sample(30);
        check("ack flash", tog_n >= 6, 1);
        check("pin0 act", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 0);
        press(BTN_PGM, 1);
        check("pin0 act", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 3'b001);
        press(BTN_ON, 1);
        step(30);
        press(BTN_PGM, 4);
        check("pin1 fn", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 3'b100);
        press(BTN_ON, 1);
        step(30);
        press(BTN_PGM, 2);
        check("pin1 act wrap", {lamps.audition_bus_select, lamps.pfl, lamps.on_green}, 0);
        press(BTN_PGM, 1);
        press(BTN_ON, 1);
        check("setup_active", setup_active, 0);
        check("stored pin1", nv_rd.pin[1], {ACT_CHON, 3'h4});
        check("writes", wr_count, 4);
        set_ext(1'b1);
        check("chan_on", chan_on, 1);
        set_ext(1'b0);
        check("chan_on latched", chan_on, 1);
        check("gpio_oe", gpio_oe, 2'b10);
        @(posedge clk_sys);
        fader <= 1'b1;
        step(6);
        check("chan_live", chan_live, 1);
        check("fader_open", fader_open, 1);
        check("gpio_o live", gpio_o[1], 0);
        @(posedge clk_sys);
        fader <= 1'b0;
        step(6);
        check("gpio_o idle", gpio_o[1], 1);
        check("fader_open off", fader_open, 0);
        set_ext(1'b1);
        check("chan_on toggled", chan_on, 0);
        set_ext(1'b0);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        step(6);
        check("gpio_oe kept", gpio_oe, 2'b10);
        hold_both(45);
        check("mode setup", setup_active, 1);
        press(BTN_PGM, 4);
        press(BTN_AUD, 2);
        press(BTN_INP, 1);
        press(BTN_ON, 4);
        sample(SLOTS * 2);
        check("aud flashes", lit_n, 6);
        hold_both(25);
        check("mode setup", setup_active, 0);
        check("stored on mode", nv_rd.mode[BTN_ON], ON_MD_PIN5);
        check("pgm_route", pgm_route, 1);
        check("aud_route", aud_route, 0);
        check("second_input_select_sel", second_input_select_sel, 1);
        check("chan_on", chan_on, 1);
        check("on_red", lamps.on_red, 0);
        press(BTN_PGM, 1);
        check("pgm_route", pgm_route, 1);
        complete_run;
    end
endmodule
